// >>> rtl/pllsd_pkg.sv
// constants shared by both ends of the synthesiser serial link
// Summary of operation
// [R01] four words msb first: swallow, main, band, reference
// [R02] data sampled on serial clock falling edge
// [R03] under 30 edges: reference latch kept
// [R04] 30 edges: reference latch also loaded
// [R05] enable low ignores data and clock
// [R06] enable fall transfers latches, resyncs detector
// [R07] host moves enable only while clock high
// [R08] band word shown on two outputs
// [R09] modulus low until swallow done, then high
// [R10] swallow 0-127, main 3-1023, main >= swallow
// [R11] reference 3-2047, divides oscillator by twice
// [R12] coarse output: up, down, or released
// [R13] lock flag pulls low inside window
// [R14] main counter terminal on open-drain monitor
// [R15] swallow/main counters clocked by prescaled input
// [R16] host keeps ratio at least N squared minus N
// [R17] counters change on their clock's rising edge
// [R18] new values adopted only at zero state
// [R19] edge count cleared when enable rises
package pllsd_pkg;
  localparam int SWALLOW_W = 7;
  localparam int MAIN_W = 10;
  localparam int BAND_W = 2;
  localparam int REF_W = 11;
  localparam int FRAME_W = SWALLOW_W + MAIN_W + BAND_W + REF_W;
  localparam int SHORT_W = SWALLOW_W + MAIN_W + BAND_W;
  localparam logic [4:0] FULL_EDGES = 5'h1E;
  localparam logic [MAIN_W-1:0] MAIN_MIN = 10'h003;
  localparam logic [REF_W-1:0] REF_MIN = 11'h003;
  localparam logic [REF_W-1:0] REF_RESET = 11'h190;
  localparam logic [MAIN_W-1:0] MAIN_RESET = 10'h157;
  localparam logic [SWALLOW_W-1:0] SWALLOW_RESET = 7'h30;
  // fine window width in device clock cycles
  localparam logic [3:0] LOCK_WINDOW = 4'h2;
  // serial clock half period from host, in hclk cycles less one (200 ns period)
  localparam logic [7:0] SCLK_HALF = 8'h04;
  localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFF_SWMAIN = 32'h0000_0004;
  localparam logic [31:0] OFF_BANDREF = 32'h0000_0008;
  localparam logic [31:0] OFF_STATUS = 32'h0000_000C;
  localparam logic [31:0] OFF_IRQ = 32'h0000_0010;
  localparam logic [31:0] OFF_MASK = 32'h0000_0014;
endpackage : pllsd_pkg

// >>> rtl/pllsd_link_if.sv
// serial loading link between host loader and synthesiser core
`timescale 1ns/1ps
interface pllsd_link_if;
  logic ser_data;
  logic ser_clk;
  logic ser_enable;
  modport host (output ser_data, output ser_clk, output ser_enable);
  modport dev (input ser_data, input ser_clk, input ser_enable);
endinterface : pllsd_link_if

// >>> rtl/pllsd_core.sv
// synthesiser core: serial latches, dividers, phase detector
`timescale 1ns/1ps
module pllsd_core
(
  input wire logic hclk,
  input wire logic hresetn,
  pllsd_link_if.dev link,
  input wire logic osc_in,
  input wire logic prescaled_vco_in,
  output logic prescaler_modulus_select,
  output logic [1:0] band_sel,
  output logic ref_div_pulse,
  output logic vco_div_monitor_o,
  output logic vco_div_monitor_oe,
  output logic coarse_error_out_o,
  output logic coarse_error_out_oe,
  output logic lock_flag_n_o,
  output logic lock_flag_n_oe
);
  localparam int FW = pllsd_pkg::FRAME_W;
  localparam int SW = pllsd_pkg::SWALLOW_W;
  localparam int MW = pllsd_pkg::MAIN_W;
  localparam int RW = pllsd_pkg::REF_W;

  // two-flop synchronisers for every outside input
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // idle levels: serial clock high, all else low, so no false edge
      s1_r <= 5'h02;
      s2_r <= 5'h02;
      s3_r <= 5'h02;
    end
    else
    begin
      s1_r <= {prescaled_vco_in, osc_in, link.ser_enable, link.ser_clk,
               link.ser_data};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  wire sdat = s2_r[0];
  wire sclk_fall = s3_r[1] & ~s2_r[1];
  wire en_rise = ~s3_r[2] & s2_r[2];
  wire en_fall = s3_r[2] & ~s2_r[2];
  wire osc_rise = ~s3_r[3] & s2_r[3];
  wire vco_rise = ~s3_r[4] & s2_r[4];

  // input shift register and edge count
  logic [FW-1:0] shift_r;
  logic [4:0] edges_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift_r <= '0;
      edges_r <= 5'h00;
    end
    else if (en_rise)
      edges_r <= 5'h00; // R19
    else if (s2_r[2] && sclk_fall) // R05
    begin
      shift_r <= {shift_r[FW-2:0], sdat}; // R02 R01
      if (edges_r != pllsd_pkg::FULL_EDGES)
        edges_r <= edges_r + 5'h01;
    end
  end

  // counter latches; short frame sits in low bits of shift register
  logic [SW-1:0] sw_lat_r;
  logic [MW-1:0] main_lat_r;
  logic [RW-1:0] ref_lat_r;
  logic [1:0] band_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sw_lat_r <= pllsd_pkg::SWALLOW_RESET;
      main_lat_r <= pllsd_pkg::MAIN_RESET;
      ref_lat_r <= pllsd_pkg::REF_RESET;
      band_r <= 2'h0;
    end
    else if (en_fall) // R06
    begin
      if (edges_r == pllsd_pkg::FULL_EDGES)
      begin
        {sw_lat_r, main_lat_r, band_r, ref_lat_r} <= shift_r; // R04
      end
      else
      begin
        // fewer edges: reference latch untouched
        {sw_lat_r, main_lat_r, band_r} <=
          shift_r[pllsd_pkg::SHORT_W-1:0]; // R03
      end
    end
  end
  assign band_sel = band_r; // R08

  // reference divider: half period of ref_lat counts of osc
  logic [RW-1:0] ref_cnt_r;
  logic ref_ph_r;
  logic ref_tick;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_cnt_r <= '0;
      ref_ph_r <= 1'b0;
    end
    else if (osc_rise) // R17
    begin
      if (ref_cnt_r == '0)
      begin
        // reload only at zero so a change never truncates a cycle
        ref_cnt_r <= ((ref_lat_r < pllsd_pkg::REF_MIN) ?
                      pllsd_pkg::REF_MIN : ref_lat_r) - 11'h001; // R18 R11
        ref_ph_r <= ~ref_ph_r;
      end
      else
        ref_cnt_r <= ref_cnt_r - 11'h001;
    end
  end
  assign ref_tick = osc_rise && ref_cnt_r == '0 && !ref_ph_r;
  assign ref_div_pulse = ref_ph_r;

  // swallow and main counters on prescaled vco
  logic [SW-1:0] sw_cnt_r;
  logic [MW-1:0] main_cnt_r;
  logic mod_r;
  logic vco_tick;
  wire [MW-1:0] main_load = (main_lat_r < pllsd_pkg::MAIN_MIN) ?
                            pllsd_pkg::MAIN_MIN : main_lat_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sw_cnt_r <= '0;
      main_cnt_r <= '0;
      mod_r <= 1'b0;
    end
    // no restart on load: new counts wait for the zero state
    else if (vco_rise) // R15 R17
    begin
      if (main_cnt_r == '0)
      begin
        main_cnt_r <= main_load - 10'h001; // R18 R10
        sw_cnt_r <= sw_lat_r;
        mod_r <= (sw_lat_r == '0); // R09
      end
      else
      begin
        main_cnt_r <= main_cnt_r - 10'h001;
        if (sw_cnt_r == 7'h01 || sw_cnt_r == '0)
          mod_r <= 1'b1; // R09
        if (sw_cnt_r != '0)
          sw_cnt_r <= sw_cnt_r - 7'h01;
      end
    end
  end
  // low for swallow count, high until main ends
  assign prescaler_modulus_select = mod_r; // R09
  assign vco_tick = vco_rise && main_cnt_r == '0;

  // terminal flag of main counter on monitor
  logic mon_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mon_r <= 1'b0;
    else if (vco_rise)
      mon_r <= (main_cnt_r == 10'h001); // R14
  end
  assign vco_div_monitor_o = 1'b0;
  assign vco_div_monitor_oe = mon_r; // R14

  // phase/frequency detector on reference and vco ticks
  logic up_r;
  logic dn_r;
  logic [3:0] gap_r;
  logic lock_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
      gap_r <= 4'h0;
      lock_r <= 1'b0;
    end
    // a load restarts the detector so both inputs meet afresh
    else if (en_fall) // R06
    begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
      gap_r <= 4'h0;
    end
    else
    begin
      if ((up_r | vco_tick) & (dn_r | ref_tick))
      begin
        // both arrived: error ends; lock when gap was small
        up_r <= 1'b0;
        dn_r <= 1'b0;
        lock_r <= (gap_r <= pllsd_pkg::LOCK_WINDOW); // R13
        gap_r <= 4'h0;
      end
      else
      begin
        up_r <= up_r | vco_tick;
        dn_r <= dn_r | ref_tick;
        if ((up_r | dn_r) && gap_r != 4'hF)
          gap_r <= gap_r + 4'h1;
      end
    end
  end
  // errors shorter than the window stay released
  wire big = gap_r >= pllsd_pkg::LOCK_WINDOW;
  assign coarse_error_out_oe = (up_r | dn_r) & big; // R12
  assign coarse_error_out_o = up_r; // R12
  assign lock_flag_n_o = 1'b0;
  assign lock_flag_n_oe = lock_r; // R13
endmodule : pllsd_core

// >>> rtl/pllsd_host.sv
// host loader: ahb-lite registers driving the serial link
`timescale 1ns/1ps
module pllsd_host
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  pllsd_link_if.host link
);
  typedef enum logic [1:0] {IDLE = 2'b00, SHIFT = 2'b01,
                            ENDING = 2'b11} pllsd_st_e;
  pllsd_st_e st_r;
  logic [31:0] swmain_r;
  logic [31:0] bandref_r;
  logic [1:0] irq_r;
  logic [1:0] mask_r;
  logic [29:0] frame_r;
  logic [4:0] left_r;
  logic [7:0] div_r;
  logic wr_pend_r;
  logic [31:0] addr_r;
  logic go;
  logic refused;
  logic done;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irq_r & mask_r);

  // ahb address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 32'h0000_0000;
    end
    else if (hready)
    begin
      wr_pend_r <= hsel & htrans[1] & hwrite;
      addr_r <= haddr;
    end
  end
  wire wr = wr_pend_r;
  assign go = wr && addr_r == pllsd_pkg::OFF_CTRL && hwdata[0] &&
              st_r == IDLE;
  // start while a frame is still going out: ignored, but flagged
  assign refused = wr && addr_r == pllsd_pkg::OFF_CTRL && hwdata[0] &&
                   st_r != IDLE;

  // data registers and interrupt bits; set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      swmain_r <= 32'h0000_0000;
      bandref_r <= 32'h0000_0000;
      irq_r <= 2'h0;
      mask_r <= 2'h0;
    end
    else
    begin
      if (wr && addr_r == pllsd_pkg::OFF_SWMAIN)
        swmain_r <= hwdata;
      if (wr && addr_r == pllsd_pkg::OFF_BANDREF)
        bandref_r <= hwdata;
      if (wr && addr_r == pllsd_pkg::OFF_MASK)
        mask_r <= hwdata[1:0];
      irq_r <= (irq_r & ~((wr && addr_r == pllsd_pkg::OFF_IRQ) ?
               hwdata[1:0] : 2'h0)) | {refused, done};
    end
  end

  // read data decoded from the address registered in the address phase
  always_comb
  begin
    case (addr_r)
      pllsd_pkg::OFF_SWMAIN: hrdata = swmain_r;
      pllsd_pkg::OFF_BANDREF: hrdata = bandref_r;
      pllsd_pkg::OFF_STATUS: hrdata = {31'h0, st_r != IDLE};
      pllsd_pkg::OFF_IRQ: hrdata = {30'h0, irq_r};
      pllsd_pkg::OFF_MASK: hrdata = {30'h0, mask_r};
      default: hrdata = 32'h0000_0000;
    endcase
  end

  // serial engine: clock idles high, enable moves with clock high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= IDLE;
      frame_r <= '0;
      left_r <= 5'h00;
      div_r <= 8'h00;
      link.ser_clk <= 1'b1;
      link.ser_enable <= 1'b0;
      link.ser_data <= 1'b0;
    end
    else
    begin
      case (st_r)
        IDLE:
          if (go)
          begin
            // swallow, main, band, reference msb first
            frame_r <= {swmain_r[22:16], swmain_r[9:0],
                        bandref_r[17:16], bandref_r[10:0]}; // R01
            // first bit settles a whole half period before the fall
            link.ser_data <= swmain_r[22];
            left_r <= hwdata[1] ? pllsd_pkg::FULL_EDGES :
                      5'(pllsd_pkg::SHORT_W);
            link.ser_enable <= 1'b1; // R07
            div_r <= pllsd_pkg::SCLK_HALF;
            st_r <= SHIFT;
          end
        SHIFT:
          if (div_r != 8'h00)
            div_r <= div_r - 8'h01;
          else
          begin
            div_r <= pllsd_pkg::SCLK_HALF;
            if (link.ser_clk)
            begin
              if (left_r == 5'h00)
                st_r <= ENDING;
              else
                link.ser_clk <= 1'b0;
            end
            else
            begin
              // data moves only on the rise, never at the sampling fall
              link.ser_clk <= 1'b1;
              link.ser_data <= frame_r[28];
              frame_r <= {frame_r[28:0], 1'b0};
              left_r <= left_r - 5'h01;
            end
          end
        ENDING:
          if (div_r != 8'h00)
            div_r <= div_r - 8'h01;
          else
          begin
            link.ser_enable <= 1'b0; // R07
            st_r <= IDLE;
          end
        default: st_r <= IDLE;
      endcase
    end
  end
  assign done = st_r == ENDING && div_r == 8'h00;
endmodule : pllsd_host

// >>> dv/pllsd_link_sva.sv
// link checker: serial framing seen on the host-to-core wires
`timescale 1ns/1ps
module pllsd_link_sva
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic ser_enable
);
  logic [5:0] falls_r;
  // falls per frame; cleared while enable is low
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      falls_r <= 6'h00;
    else if (!ser_enable)
      falls_r <= 6'h00;
    else if ($fell(ser_clk))
      falls_r <= falls_r + 6'h01;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_low; !ser_clk [*5] ##1 ser_clk; endsequence
  sequence s_high; ser_clk [*5]; endsequence
  property p_en_clk_high;
    $changed(ser_enable) |-> ser_clk && $past(ser_clk);
  endproperty
  property p_low; $fell(ser_clk) |-> s_low; endproperty
  property p_high; $rose(ser_clk) && ser_enable |-> s_high; endproperty
  property p_fall_in_frame; $fell(ser_clk) |-> ser_enable; endproperty
  property p_frame_len;
    $fell(ser_enable) |-> falls_r == 6'h13 || falls_r == 6'h1E;
  endproperty
  property p_max_falls; falls_r <= 6'h1E; endproperty
  property p_frame_bound; $rose(ser_enable) |-> ##[1:400] !ser_enable;
  endproperty
  property p_idle; !ser_enable |-> ser_clk; endproperty
  a_en_clk_high: assert property (p_en_clk_high)
    else $error("enable moved while clock low");
  a_low: assert property (p_low)
    else $error("clock low phase length wrong");
  a_high: assert property (p_high)
    else $error("clock high phase length wrong");
  a_fall_in_frame: assert property (p_fall_in_frame)
    else $error("clock fell outside a frame");
  a_frame_len: assert property (p_frame_len)
    else $error("frame length not 19 or 30");
  a_max_falls: assert property (p_max_falls)
    else $error("more than 30 bits in a frame");
  a_frame_bound: assert property (p_frame_bound)
    else $error("frame never closed");
  a_idle: assert property (p_idle)
    else $error("clock not idle high");
endmodule : pllsd_link_sva

// >>> dv/tb.sv
// self-checking bench: host loader driving the core over the link
`timescale 1ns/1ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic osc_in = 1'b0;
  logic vco_in = 1'b0;
  logic hready, hresp, irq, mod_sel, ref_pulse, mon_o, mon_oe;
  logic [31:0] hrdata;
  logic [1:0] band_sel;
  logic pd_o, pd_oe, lk_o, lk_oe;
  logic [2:0] watch;
  int fail_count = 0;
  int checks = 0;
  pllsd_link_if pllsd_link_if_inst();
  pllsd_host pllsd_host_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .link(pllsd_link_if_inst.host));
  pllsd_core pllsd_core_inst (.hclk(hclk), .hresetn(hresetn),
    .link(pllsd_link_if_inst.dev), .osc_in(osc_in),
    .prescaled_vco_in(vco_in), .prescaler_modulus_select(mod_sel),
    .band_sel(band_sel), .ref_div_pulse(ref_pulse),
    .vco_div_monitor_o(mon_o), .vco_div_monitor_oe(mon_oe),
    .coarse_error_out_o(pd_o), .coarse_error_out_oe(pd_oe),
    .lock_flag_n_o(lk_o), .lock_flag_n_oe(lk_oe));
  assign watch = {mon_oe, mod_sel, ref_pulse};
  pllsd_link_sva pllsd_link_sva_inst (.hclk(hclk), .hresetn(hresetn),
    .ser_data(pllsd_link_if_inst.ser_data),
    .ser_clk(pllsd_link_if_inst.ser_clk),
    .ser_enable(pllsd_link_if_inst.ser_enable));
  // clocks; osc and vco edges kept off the hclk rising edge
  always #10 hclk = ~hclk;
  always #40 osc_in = ~osc_in;
  initial
  begin
    #2;
    forever #50 vco_in = ~vco_in;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // one single transfer; waits on hready, the watchdog bounds it
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  // load a frame, wait for the done flag, check irq, then clear it
  task automatic load(input logic [31:0] sm, input logic [31:0] br,
    input logic [31:0] ctl, input logic exp_irq);
    logic [31:0] q;
    bus(1'b1, pllsd_pkg::OFF_SWMAIN, sm, q);
    bus(1'b1, pllsd_pkg::OFF_BANDREF, br, q);
    bus(1'b1, pllsd_pkg::OFF_CTRL, ctl, q);
    do bus(1'b0, pllsd_pkg::OFF_IRQ, 32'h0, q); while (q[0] !== 1'b1);
    cmp({31'h0, irq}, {31'h0, exp_irq});
    bus(1'b1, pllsd_pkg::OFF_IRQ, 32'h1, q);
    @(posedge hclk);
    cmp({31'h0, irq}, 32'h0);
  endtask : load
  // hclk cycles between rises of watch[k], or its low phase when lo
  task automatic span(input logic [1:0] k, input logic lo,
    input logic [31:0] exp);
    logic [31:0] n;
    logic prev;
    int rises;
    n = 32'h0;
    rises = 0;
    prev = watch[k];
    while (rises < 4)
    begin
      @(posedge hclk);
      if (rises == 3 && (!lo || !watch[k]))
        n = n + 32'h1;
      if (watch[k] && !prev)
        rises++;
      prev = watch[k];
    end
    cmp(n, exp);
  endtask : span
  task automatic t_reset();
    logic [31:0] q;
    cmp({30'h0, band_sel}, 32'h0);
    bus(1'b0, pllsd_pkg::OFF_STATUS, 32'h0, q);
    cmp(q, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_full();
    logic [31:0] q;
    bus(1'b1, pllsd_pkg::OFF_MASK, 32'h1, q);
    load(32'h0003_000A, 32'h0002_0005, 32'h3, 1'b1);
    cmp({30'h0, band_sel}, 32'h2);
    span(2'h0, 1'b0, 32'h28);
    span(2'h1, 1'b0, 32'h32);
    span(2'h1, 1'b1, 32'hF);
    span(2'h2, 1'b0, 32'h32);
    $display("test full frame done");
  endtask : t_full
  task automatic t_short();
    logic [31:0] q;
    bus(1'b1, pllsd_pkg::OFF_MASK, 32'h0, q);
    bus(1'b1, 32'h0000_0020, 32'h1, q);
    bus(1'b0, pllsd_pkg::OFF_MASK, 32'h0, q);
    cmp(q, 32'h0);
    load(32'h0004_000C, 32'h0001_0007, 32'h1, 1'b0);
    cmp({30'h0, band_sel}, 32'h1);
    span(2'h0, 1'b0, 32'h28);
    span(2'h1, 1'b0, 32'h3C);
    span(2'h1, 1'b1, 32'h14);
    $display("test short frame done");
  endtask : t_short
  // coarse output may only drive the direction of the faster input
  task automatic t_detect(input logic up);
    logic [31:0] hits;
    logic [31:0] miss;
    logic [31:0] locked;
    hits = 32'h0;
    miss = 32'h0;
    locked = 32'h0;
    // let a new main count take over at its zero state first
    repeat (200) @(posedge hclk);
    repeat (1000)
    begin
      @(posedge hclk);
      if (pd_oe === 1'b1 && pd_o === up)
        hits = hits + 32'h1;
      if (pd_oe === 1'b1 && pd_o !== up)
        miss = miss + 32'h1;
      if (lk_oe === 1'b1)
        locked = locked + 32'h1;
    end
    cmp({31'h0, hits != 32'h0}, 32'h1);
    cmp(miss, 32'h0);
    cmp({31'h0, locked < 32'h3E8}, 32'h1);
    cmp({30'h0, lk_o, mon_o}, 32'h0);
    $display("test detector done");
  endtask : t_detect
  // a start while busy is ignored and flagged in irq bit 1
  task automatic t_refuse();
    logic [31:0] q;
    bus(1'b1, pllsd_pkg::OFF_SWMAIN, 32'h0002_0006, q);
    bus(1'b1, pllsd_pkg::OFF_CTRL, 32'h1, q);
    bus(1'b1, pllsd_pkg::OFF_CTRL, 32'h3, q);
    bus(1'b0, pllsd_pkg::OFF_STATUS, 32'h0, q);
    cmp(q, 32'h1);
    bus(1'b0, pllsd_pkg::OFF_IRQ, 32'h0, q);
    cmp(q, 32'h2);
    do bus(1'b0, pllsd_pkg::OFF_IRQ, 32'h0, q); while (q[0] !== 1'b1);
    bus(1'b1, pllsd_pkg::OFF_IRQ, 32'h3, q);
    bus(1'b0, pllsd_pkg::OFF_IRQ, 32'h0, q);
    cmp(q, 32'h0);
    cmp({30'h0, band_sel}, 32'h1);
    t_detect(1'b1);
    $display("test refused start done");
  endtask : t_refuse
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_full();
    t_detect(1'b0);
    t_short();
    t_refuse();
    final_report();
  end
  initial
  begin
    #500000;
    fail_count++;
    final_report();
  end
endmodule : tb
